// ### verilog/scannable_eight_bit_register.sv
// Eight-bit register with parallel load, hold and serial scan shift
// Behaviour
// - Eight-bit register, parallel loadable or serially shiftable, each bit its own output.
// - Shift control forces a serial shift regardless of hold/load select.
// - Without shift, one select line picks hold through feedback or parallel load.
// - Shift takes the new bit from serial input; parallel inputs only in load.
// - Parallel load and input sampling happen only on the rising clock edge.
// - One bit position shifted per rising edge while shift is selected.
// - High master clear zeroes all bits at once, without clock, above all.
`default_nettype none
module scannable_eight_bit_register
   import scan_reg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic master_clear,
   input wire ctrl_t ctrl,
   output logic [WIDTH-1:0] data_out
);

   logic [WIDTH-1:0] data_r;
   logic [WIDTH-1:0] data_nxt;
   mode_t mode;

   // Shadow state for the scan checks only; it never feeds the word
   logic [WIDTH-1:0] serial_hist_r;
   logic [WIDTH-1:0] serial_hist_nxt;
   logic [3:0] shift_run_r;
   logic [3:0] shift_run_nxt;

   // Shift outranks the hold/load select
   always_comb begin
      if (ctrl.shift) begin
         mode = MODE_SHIFT;
      end else if (ctrl.hold_sel) begin
         mode = MODE_HOLD;
      end else begin
         mode = MODE_LOAD;
      end
   end

   // One next-state mux per bit; bit 0 is fed from the serial input
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      logic shift_src;
      logic bit_nxt;

      if (b == SERIAL_IN_POS) begin : g_first
         assign shift_src = ctrl.serial_in;
      end else begin : g_upper
         assign shift_src = data_r[b-1];
      end

      always_comb begin
         unique case (mode)
            MODE_SHIFT: begin
               bit_nxt = shift_src;
            end
            MODE_HOLD: begin
               bit_nxt = data_r[b];
            end
            MODE_LOAD: begin
               bit_nxt = ctrl.parallel_inputs[b];
            end
            default: begin
               bit_nxt = data_r[b];
            end
         endcase
      end

      assign data_nxt[b] = bit_nxt;
   end

   // Either clear input zeroes the word at once, with or without a clock
   always_ff @(posedge clk or posedge rst or posedge master_clear) begin
      if (rst) begin
         data_r <= RESET_VALUE;
      end else if (master_clear) begin
         data_r <= RESET_VALUE;
      end else begin
         data_r <= data_nxt;
      end
   end

   assign data_out = data_r;

   // Serial history and a saturating count of back-to-back shifts
   always_comb begin
      serial_hist_nxt = {serial_hist_r[WIDTH-2:0], ctrl.serial_in};
      if (!ctrl.shift) begin
         shift_run_nxt = 4'h0;
      end else if (shift_run_r == 4'(WIDTH)) begin
         shift_run_nxt = shift_run_r;
      end else begin
         shift_run_nxt = shift_run_r + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge rst or posedge master_clear) begin
      if (rst) begin
         serial_hist_r <= RESET_VALUE;
         shift_run_r <= 4'h0;
      end else if (master_clear) begin
         serial_hist_r <= RESET_VALUE;
         shift_run_r <= 4'h0;
      end else begin
         serial_hist_r <= serial_hist_nxt;
         shift_run_r <= shift_run_nxt;
      end
   end

   // Load and hold
   a_load_takes_inputs: assert property (
      @(posedge clk)
      disable iff (rst || master_clear)
      (!ctrl.shift && !ctrl.hold_sel)
      |=> (data_out == $past(ctrl.parallel_inputs))
   ) else $error("parallel load did not capture inputs");

   a_hold_keeps_word: assert property (
      @(posedge clk)
      disable iff (rst || master_clear)
      (!ctrl.shift && ctrl.hold_sel)
      |=> $stable(data_out)
   ) else $error("hold changed the word");

   a_hold_high_sel: assert property (
      @(posedge clk)
      disable iff (rst || master_clear)
      (!ctrl.shift && ctrl.hold_sel && ctrl.parallel_inputs != data_out)
      |=> (data_out == $past(data_out))
   ) else $error("high select loaded the inputs");

   a_output_is_reg: assert property (
      @(posedge clk)
      disable iff (rst || master_clear)
      (!ctrl.shift && !ctrl.hold_sel) ##1 (!ctrl.shift && ctrl.hold_sel) [*2]
      |-> (data_out == $past(ctrl.parallel_inputs, 2))
   ) else $error("loaded word not kept on outputs");

   a_load_sel_low: assert property (
      @(posedge clk)
      disable iff (rst || master_clear)
      (!ctrl.shift && !ctrl.hold_sel && ctrl.parallel_inputs != data_out)
      |=> !$stable(data_out)
   ) else $error("low select did not load");

   a_each_bit_output: assert property (
      @(posedge clk)
      disable iff (rst || master_clear)
      (!ctrl.shift && !ctrl.hold_sel) ##1 ctrl.shift
      |=> (data_out[WIDTH-1:1] == $past(ctrl.parallel_inputs[WIDTH-2:0], 2))
   ) else $error("loaded bits did not shift up on their outputs");

   // Shift
   a_shift_moves_up: assert property (
      @(posedge clk)
      disable iff (rst || master_clear)
      ctrl.shift
      |=> (data_out[WIDTH-1:1] == $past(data_out[WIDTH-2:0]))
   ) else $error("shift did not move bits up by one");

   a_shift_serial_in: assert property (
      @(posedge clk)
      disable iff (rst || master_clear)
      ctrl.shift
      |=> (data_out[0] == $past(ctrl.serial_in))
   ) else $error("shift did not take serial input");

   a_shift_ignores_par: assert property (
      @(posedge clk)
      disable iff (rst || master_clear)
      (ctrl.shift && !ctrl.hold_sel)
      |=> (data_out[0] == $past(ctrl.serial_in))
   ) else $error("shift with low select took the parallel inputs");

   a_shift_over_sel: assert property (
      @(posedge clk)
      disable iff (rst || master_clear)
      (ctrl.shift && ctrl.hold_sel) ##1 ctrl.shift [*2]
      |=> (data_out[2:0] == {$past(ctrl.serial_in, 3), $past(ctrl.serial_in, 2),
      $past(ctrl.serial_in)})
   ) else $error("shift did not override hold select");

   a_scan_fills_word: assert property (
      @(posedge clk)
      disable iff (rst || master_clear)
      (shift_run_r == 4'(WIDTH))
      |-> (data_out == serial_hist_r)
   ) else $error("a full scan did not leave the serial bits in the word");

   // Clear
   a_clear_zeroes: assert property (
      @(posedge clk)
      master_clear
      |-> (data_out == RESET_VALUE)
   ) else $error("master clear did not zero the word");

   a_clear_async: assert property (
      @(posedge clk)
      rst
      |-> (data_out == RESET_VALUE)
   ) else $error("system reset did not zero the word");

   a_clear_over_shift: assert property (
      @(posedge clk)
      (master_clear && ctrl.shift)
      |-> (data_out == RESET_VALUE)
   ) else $error("shift overrode master clear");

   a_clear_release: assert property (
      @(posedge clk)
      disable iff (rst)
      $fell(master_clear)
      |-> (data_out == RESET_VALUE)
   ) else $error("word not zero when master clear was released");

endmodule
`default_nettype wire

// ### inc/scan_reg_pkg.sv
// Package for the eight-bit scannable register: widths, reset value, mode codes
`default_nettype none
package scan_reg_pkg;
   localparam int WIDTH = 8;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam int SERIAL_IN_POS = 0;

   typedef enum logic [1:0] {
      MODE_LOAD = 2'b00,
      MODE_HOLD = 2'b01,
      MODE_SHIFT = 2'b10
   } mode_t;

   typedef struct packed {
      logic shift;
      logic hold_sel;
      logic serial_in;
      logic [7:0] parallel_inputs;
   } ctrl_t;
endpackage
`default_nettype wire

// ### bench/ctrl_source.sv
// Far-side logic model: presents each control word after a falling edge
`default_nettype none
module ctrl_source
   import scan_reg_pkg::*;
(
   input wire logic clk,
   input wire ctrl_t req,
   output var ctrl_t ctrl
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(negedge clk) ctrl <= req;
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the scannable register
`default_nettype none
module tb_top;
   import scan_reg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, master_clear = 0;
   ctrl_t req = '0, ctrl;
   logic [7:0] data_out, exp_r = 8'h00;
   int n_mismatch = 0, samples_checked = 0;
   always #12.5 clk = ~clk;
   ctrl_source ctrl_source_i (.clk(clk), .req(req), .ctrl(ctrl));
   scannable_eight_bit_register scannable_eight_bit_register_i (.clk(clk), .rst(rst),
      .master_clear(master_clear), .ctrl(ctrl), .data_out(data_out));
   function automatic logic [7:0] next_word(logic [7:0] cur, ctrl_t c);
      if (c.shift) return {cur[6:0], c.serial_in};
      return c.hold_sel ? cur : c.parallel_inputs;
   endfunction
   always @(posedge clk or posedge rst or posedge master_clear) begin
      exp_r <= (rst || master_clear) ? 8'h00 : next_word(exp_r, ctrl);
   end
   task automatic check(logic [7:0] exp);
      samples_checked++;
      if (data_out !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h exp %h", $time, data_out, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hd31bddd3));
      repeat (20) @(negedge clk);
      for (int i = 0; i < 400; i++) begin
         @(negedge clk);
         check(exp_r);
         req <= (i < 8) ? ctrl_t'({i[2:0], 8'hc3}) :
            (i < 20) ? ctrl_t'({2'b11, i[0], 8'h5a}) : ctrl_t'(11'($urandom));
         master_clear <= (i % 50 == 25);
         rst <= (i == 200);
         #1 if (master_clear || rst) check(8'h00);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
